//--- pkg/slc_defs.svh
// Constants of the switch bus lock controller.
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

`define SLC_NPORTS 8
`define SLC_PORT_W 3
`define SLC_UP_PORT 3'h0

`define SLC_KIND_W 3
`define SLC_KIND_MWR 3'h0
`define SLC_KIND_MRD 3'h1
`define SLC_KIND_LKRD 3'h2
`define SLC_KIND_UNLOCK 3'h3
`define SLC_KIND_CFG 3'h4
`define SLC_KIND_MSG 3'h5
`define SLC_KIND_CPL 3'h6

`define SLC_STS_W 8
`define SLC_STS_RESET 8'h00
`define SLC_STS_SWITCH_LOCKED_BIT 0

`endif

//--- pkg/slc_pkg.sv
// Types and helpers of the switch bus lock controller.
`include "slc_defs.svh"
`default_nettype none

package slc_pkg;

   typedef enum logic [2:0] {
      SLC_IDLE = 3'b000,
      SLC_RD_DRAIN = 3'b001,
      SLC_DN_LOCK = 3'b010,
      SLC_CPL_DRAIN = 3'b011,
      SLC_SW_LOCK = 3'b100,
      SLC_FAIL_HOLD = 3'b101,
      SLC_UNL_DRAIN = 3'b110
   } slc_state_t;

   // TLP header seen on the upstream port
   typedef struct packed {
      logic valid;
      logic [`SLC_KIND_W-1:0] kind;
      logic [`SLC_PORT_W-1:0] dest;
   } slc_up_tlp_t;

   // Completion returned by a downstream port
   typedef struct packed {
      logic valid;
      logic locked;
      logic with_data;
      logic [`SLC_PORT_W-1:0] src;
   } slc_dn_cpl_t;

   // Head TLP waiting at a downstream port
   typedef struct packed {
      logic valid;
      logic [`SLC_PORT_W-1:0] dest;
   } slc_dn_head_t;

   function automatic logic [`SLC_NPORTS-1:0] slc_port_bit(input logic [`SLC_PORT_W-1:0] p);
      logic [`SLC_NPORTS-1:0] v;
      v = {{(`SLC_NPORTS-1){1'b0}}, 1'b1};
      slc_port_bit = v << p;
   endfunction

endpackage

`default_nettype wire

//--- logic/slc_block_gate.sv
// Per-source hold gate for downstream TLPs during a lock.
`include "slc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module slc_block_gate #(
   parameter logic [`SLC_PORT_W-1:0] SRC_PORT = 3'h1
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire slc_pkg::slc_dn_head_t head_in,
   input wire logic [`SLC_NPORTS-1:0] block_vec_in,
   input wire logic lock_active_in,
   input wire logic [`SLC_PORT_W-1:0] locked_port_in,
   output logic hold_out
);

   logic own_lock_port;
   logic dest_blocked;
   logic next_hold;

   // Locked port keeps inserting its own messages and MSIs
   assign own_lock_port = lock_active_in && (locked_port_in == SRC_PORT); // see R13
   assign dest_blocked = |(block_vec_in & slc_pkg::slc_port_bit(head_in.dest)); // see R4
   // Held, never dropped: the source keeps the TLP at its queue head
   assign next_hold = head_in.valid && dest_blocked && !own_lock_port; // see R16

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_out <= 1'b0; // see R19
      end else begin
         hold_out <= next_hold; // see R2
      end
   end

endmodule

`default_nettype wire

//--- logic/slc_lock_ctrl.sv
// Lock sequence control of the switch: state, ordering and blocking.
`include "slc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1: Only one lock sequence at a time
// R2: Locked read locks target port, holds others
// R3: Drain posted to port before locked read
// R4: Other destinations stay open while port-locked
// R5: Locked data completion locks switch: upstream port closed too
// R6: Root always ends lock with Unlock
// R7: Failed lock state released only by Unlock
// R8: Drain posted upstream before the locked data completion that locks the switch
// R9: SMBus register access unaffected by lock
// R10: Root avoids config access while locked
// R11: Root sends only writes, locked reads, Unlock
// R12: Later locked traffic leaves lock unchanged
// R13: Upstream and locked port insert messages
// R14: Unlock frees switch, forwards Unlock downstream
// R15: Drain upstream posted before unlocking
// R16: Blocked TLPs are held, not dropped
// R17: Root targets only the locked port
// R18: Switch lock state shown as status bit
// R19: Reset gives unlocked, nothing blocked
module slc_lock_ctrl (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire slc_pkg::slc_up_tlp_t up_tlp_in,
   input wire slc_pkg::slc_dn_cpl_t dn_cpl_in,
   input wire slc_pkg::slc_dn_head_t [`SLC_NPORTS-1:0] dn_head_in,
   input wire logic [`SLC_NPORTS-1:0] posted_dn_empty_in,
   input wire logic [`SLC_NPORTS-1:0] posted_up_empty_in,
   input wire logic posted_root_empty_in,
   output logic fwd_lkrd_out,
   output logic [`SLC_PORT_W-1:0] fwd_lkrd_port_out,
   output logic fwd_cpl_out,
   output logic fwd_cpl_data_out,
   output logic fwd_unlock_out,
   output logic [`SLC_PORT_W-1:0] fwd_unlock_port_out,
   output logic dn_locked_out,
   output logic [`SLC_PORT_W-1:0] locked_port_out,
   output logic switch_locked_flag_out,
   output logic [`SLC_STS_W-1:0] switch_status_register_out,
   output logic [`SLC_NPORTS-1:0] hold_out,
   output logic viol_out
);

   slc_pkg::slc_state_t state;
   slc_pkg::slc_state_t next_state;
   logic [`SLC_PORT_W-1:0] locked_port;
   logic [`SLC_PORT_W-1:0] next_locked_port;
   logic up_locked;
   logic next_up_locked;

   logic up_v;
   logic up_lkrd;
   logic up_unlock;
   logic up_to_locked;
   logic cpl_hit;
   logic lock_active;
   logic port_drained;
   logic up_drained;

   logic next_fwd_lkrd;
   logic next_fwd_cpl;
   logic next_fwd_cpl_data;
   logic next_fwd_unlock;
   logic next_viol;
   logic [`SLC_NPORTS-1:0] block_vec;
   logic [`SLC_STS_W-1:0] next_status;

   assign up_v = up_tlp_in.valid;
   assign up_lkrd = up_v && (up_tlp_in.kind == `SLC_KIND_LKRD);
   assign up_unlock = up_v && (up_tlp_in.kind == `SLC_KIND_UNLOCK);
   assign up_to_locked = up_tlp_in.dest == locked_port;
   assign cpl_hit = dn_cpl_in.valid && dn_cpl_in.locked && (dn_cpl_in.src == locked_port);
   assign lock_active = state != slc_pkg::SLC_IDLE;
   assign port_drained = posted_dn_empty_in[locked_port];
   assign up_drained = posted_up_empty_in[locked_port];

   // Sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         slc_pkg::SLC_IDLE: begin
            // A new sequence only starts from idle
            if (up_lkrd && (up_tlp_in.dest != `SLC_UP_PORT)) begin
               next_state = slc_pkg::SLC_RD_DRAIN; // see R1
            end
         end
         slc_pkg::SLC_RD_DRAIN: begin
            if (port_drained) begin
               next_state = slc_pkg::SLC_DN_LOCK; // see R3
            end
         end
         slc_pkg::SLC_DN_LOCK: begin
            if (up_unlock) begin
               next_state = slc_pkg::SLC_UNL_DRAIN; // see R14
            end else if (cpl_hit && dn_cpl_in.with_data) begin
               next_state = slc_pkg::SLC_CPL_DRAIN; // see R5
            end else if (cpl_hit) begin
               next_state = slc_pkg::SLC_FAIL_HOLD; // see R7
            end
         end
         slc_pkg::SLC_CPL_DRAIN: begin
            if (up_drained) begin
               next_state = slc_pkg::SLC_SW_LOCK; // see R8
            end
         end
         slc_pkg::SLC_SW_LOCK: begin
            // Further locked reads, writes and completions keep the lock
            if (up_unlock) begin
               next_state = slc_pkg::SLC_UNL_DRAIN; // see R12
            end
         end
         slc_pkg::SLC_FAIL_HOLD: begin
            // Failed lock lingers until the root's Unlock
            if (up_unlock) begin
               next_state = slc_pkg::SLC_UNL_DRAIN; // see R7
            end
         end
         slc_pkg::SLC_UNL_DRAIN: begin
            if (posted_root_empty_in) begin
               next_state = slc_pkg::SLC_IDLE; // see R15
            end
         end
         default: begin
            next_state = slc_pkg::SLC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= slc_pkg::SLC_IDLE; // see R19
      end else begin
         state <= next_state;
      end
   end

   // Target port is captured once per sequence
   always_comb begin
      next_locked_port = locked_port;
      if (state == slc_pkg::SLC_IDLE && next_state == slc_pkg::SLC_RD_DRAIN) begin
         next_locked_port = up_tlp_in.dest; // see R2
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         locked_port <= `SLC_UP_PORT;
      end else begin
         locked_port <= next_locked_port;
      end
   end

   // Upstream side lock, set only by a successful lock
   always_comb begin
      next_up_locked = up_locked;
      if (state == slc_pkg::SLC_CPL_DRAIN && up_drained) begin
         next_up_locked = 1'b1; // see R5
      end else if (state == slc_pkg::SLC_UNL_DRAIN && posted_root_empty_in) begin
         next_up_locked = 1'b0; // see R14
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         up_locked <= 1'b0;
      end else begin
         up_locked <= next_up_locked;
      end
   end

   // Forwarding strobes towards the datapath
   always_comb begin
      next_fwd_lkrd = 1'b0;
      next_fwd_cpl = 1'b0;
      next_fwd_cpl_data = 1'b0;
      next_fwd_unlock = 1'b0;
      if (state == slc_pkg::SLC_RD_DRAIN && port_drained) begin
         next_fwd_lkrd = 1'b1; // see R3
      end
      if (state == slc_pkg::SLC_SW_LOCK && up_lkrd && up_to_locked) begin
         next_fwd_lkrd = 1'b1; // see R12
      end
      if (state == slc_pkg::SLC_CPL_DRAIN && up_drained) begin
         next_fwd_cpl = 1'b1; // see R8
         next_fwd_cpl_data = 1'b1;
      end
      if (state == slc_pkg::SLC_DN_LOCK && cpl_hit && !dn_cpl_in.with_data) begin
         next_fwd_cpl = 1'b1; // see R7
      end
      if (state == slc_pkg::SLC_SW_LOCK && cpl_hit) begin
         next_fwd_cpl = 1'b1; // see R12
         next_fwd_cpl_data = dn_cpl_in.with_data;
      end
      if (state == slc_pkg::SLC_UNL_DRAIN && posted_root_empty_in) begin
         next_fwd_unlock = 1'b1; // see R14
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fwd_lkrd_out <= 1'b0;
         fwd_cpl_out <= 1'b0;
         fwd_cpl_data_out <= 1'b0;
         fwd_unlock_out <= 1'b0;
      end else begin
         fwd_lkrd_out <= next_fwd_lkrd;
         fwd_cpl_out <= next_fwd_cpl;
         fwd_cpl_data_out <= next_fwd_cpl_data;
         fwd_unlock_out <= next_fwd_unlock;
      end
   end

   // Port fields show the new target in the same cycle as dn_locked_out
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fwd_lkrd_port_out <= `SLC_UP_PORT;
         fwd_unlock_port_out <= `SLC_UP_PORT;
         locked_port_out <= `SLC_UP_PORT;
         dn_locked_out <= 1'b0;
      end else begin
         fwd_lkrd_port_out <= next_locked_port;
         fwd_unlock_port_out <= next_locked_port; // see R14
         locked_port_out <= next_locked_port;
         dn_locked_out <= next_state != slc_pkg::SLC_IDLE;
      end
   end

   // Status word; the SMBus path reads it whatever the lock state
   always_comb begin
      next_status = `SLC_STS_RESET;
      next_status[`SLC_STS_SWITCH_LOCKED_BIT] = next_up_locked; // see R18
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         switch_status_register_out <= `SLC_STS_RESET;
         switch_locked_flag_out <= 1'b0;
      end else begin
         switch_status_register_out <= next_status; // see R9
         switch_locked_flag_out <= next_up_locked;
      end
   end

   // Only the locked port, and the upstream port once locked, are closed
   always_comb begin
      block_vec = '0;
      if (lock_active) begin
         block_vec = slc_pkg::slc_port_bit(locked_port); // see R2
      end
      if (up_locked) begin
         block_vec[`SLC_UP_PORT] = 1'b1; // see R5
      end
   end

   // Upstream port is the root's own source and is never held
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_out[0] <= 1'b0;
      end else begin
         hold_out[0] <= 1'b0; // see R13
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < `SLC_NPORTS; gi = gi + 1) begin : g_gate
         slc_block_gate #(
            .SRC_PORT(gi[`SLC_PORT_W-1:0])
         ) u_gate (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .head_in(dn_head_in[gi]),
            .block_vec_in(block_vec),
            .lock_active_in(lock_active),
            .locked_port_in(locked_port),
            .hold_out(hold_out[gi])
         );
      end
   endgenerate

   // Flags traffic that leaves switch behaviour undefined
   always_comb begin
      next_viol = 1'b0;
      if (up_locked && up_v && up_tlp_in.kind != `SLC_KIND_MWR &&
          up_tlp_in.kind != `SLC_KIND_LKRD && up_tlp_in.kind != `SLC_KIND_UNLOCK) begin
         next_viol = 1'b1; // see R11
      end
      if (up_locked && up_v && up_tlp_in.kind == `SLC_KIND_CFG) begin
         next_viol = 1'b1; // see R10
      end
      if (lock_active && up_v && !up_unlock && !up_to_locked &&
          up_tlp_in.dest != `SLC_UP_PORT) begin
         next_viol = 1'b1; // see R17
      end
      if (up_locked && dn_cpl_in.valid && !dn_cpl_in.locked &&
          dn_cpl_in.src == locked_port) begin
         next_viol = 1'b1; // see R11
      end
      if (state == slc_pkg::SLC_IDLE && up_unlock) begin
         next_viol = 1'b0; // see R6
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         viol_out <= 1'b0;
      end else begin
         viol_out <= next_viol;
      end
   end

endmodule

`default_nettype wire

//--- sim/slc_lock_props.sv
// Port assertions of the switch lock controller.
`include "slc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module slc_lock_props (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire slc_pkg::slc_up_tlp_t up_tlp_in,
   input wire slc_pkg::slc_dn_head_t [`SLC_NPORTS-1:0] dn_head_in,
   input wire logic [`SLC_NPORTS-1:0] posted_dn_empty_in,
   input wire logic [`SLC_NPORTS-1:0] posted_up_empty_in,
   input wire logic posted_root_empty_in,
   input wire logic fwd_lkrd_out,
   input wire logic [`SLC_PORT_W-1:0] fwd_lkrd_port_out,
   input wire logic fwd_cpl_out,
   input wire logic fwd_cpl_data_out,
   input wire logic fwd_unlock_out,
   input wire logic [`SLC_PORT_W-1:0] fwd_unlock_port_out,
   input wire logic dn_locked_out,
   input wire logic [`SLC_PORT_W-1:0] locked_port_out,
   input wire logic switch_locked_flag_out,
   input wire logic [`SLC_STS_W-1:0] switch_status_register_out,
   input wire logic [`SLC_NPORTS-1:0] hold_out
);
   logic [`SLC_NPORTS-1:0] to_lock;
   logic [`SLC_NPORTS-1:0] to_open;
   always_comb begin
      for (int i = 1; i < `SLC_NPORTS; i++) begin
         to_lock[i] = dn_head_in[i].valid && dn_head_in[i].dest == locked_port_out
            && i[2:0] != locked_port_out;
         to_open[i] = dn_head_in[i].valid && dn_head_in[i].dest != locked_port_out
            && dn_head_in[i].dest != `SLC_UP_PORT;
      end
      to_lock[0] = 1'b0;
      to_open[0] = 1'b0;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence lock_req;
      up_tlp_in.valid && up_tlp_in.kind == `SLC_KIND_LKRD && !dn_locked_out
         && up_tlp_in.dest != `SLC_UP_PORT;
   endsequence
   sequence lock_taken;
      dn_locked_out && locked_port_out == $past(up_tlp_in.dest);
   endsequence
   lock_start_a: assert property (lock_req |=> lock_taken)
      else $error("locked read did not lock its port");
   one_seq_a: assert property (dn_locked_out && $past(dn_locked_out) |-> $stable(locked_port_out))
      else $error("locked port changed mid sequence");
   lkrd_drain_a: assert property (fwd_lkrd_out && !switch_locked_flag_out
      |-> $past(posted_dn_empty_in[fwd_lkrd_port_out])) else $error("read sent before drain");
   cpl_drain_a: assert property (fwd_cpl_out && fwd_cpl_data_out && !$past(switch_locked_flag_out)
      |-> $past(posted_up_empty_in[locked_port_out])) else $error("completion before drain");
   sw_lock_a: assert property ($rose(switch_locked_flag_out) |-> fwd_cpl_out && fwd_cpl_data_out)
      else $error("switch locked without data completion");
   lock_keeps_a: assert property ($past(switch_locked_flag_out) && (fwd_cpl_out || fwd_lkrd_out)
      |-> switch_locked_flag_out) else $error("locked traffic changed lock");
   fail_hold_a: assert property (fwd_cpl_out && !fwd_cpl_data_out && !$past(switch_locked_flag_out)
      |-> !switch_locked_flag_out && dn_locked_out) else $error("failed lock mishandled");
   unlock_frees_a: assert property ($fell(switch_locked_flag_out) |-> fwd_unlock_out &&
      !dn_locked_out && fwd_unlock_port_out == locked_port_out) else $error("bad unlock");
   unlock_drain_a: assert property (fwd_unlock_out |-> $past(posted_root_empty_in))
      else $error("unlock before root drain");
   status_bit_a: assert property (switch_status_register_out ==
      {{(`SLC_STS_W-1){1'b0}}, switch_locked_flag_out}) else $error("status bit wrong");
   held_a: assert property (dn_locked_out && to_lock != 0 |=>
      (hold_out & $past(to_lock)) == $past(to_lock) || fwd_unlock_out) else $error("not held");
   open_a: assert property (dn_locked_out |=> (hold_out & $past(to_open)) == 0)
      else $error("open destination held");
endmodule
bind slc_lock_ctrl slc_lock_props i_slc_lock_props (.core_clk_in, .rst_in, .up_tlp_in,
   .dn_head_in, .posted_dn_empty_in, .posted_up_empty_in, .posted_root_empty_in,
   .fwd_lkrd_out, .fwd_lkrd_port_out, .fwd_cpl_out, .fwd_cpl_data_out, .fwd_unlock_out,
   .fwd_unlock_port_out, .dn_locked_out, .locked_port_out, .switch_locked_flag_out,
   .switch_status_register_out, .hold_out);
`default_nettype wire

//--- sim/slc_cpl_model.sv
// Downstream endpoint model answering forwarded locked reads.
`timescale 1ns/1ns
`default_nettype none
module slc_cpl_model (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic lkrd_in,
   input wire logic [2:0] port_in,
   input wire logic data_in,
   input wire logic [2:0] delay_in,
   output var slc_pkg::slc_dn_cpl_t cpl_out
);
   logic busy;
   logic [2:0] cnt;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy <= 1'b0;
         cnt <= 3'h0;
         cpl_out <= '0;
      end else begin
         // Idle fields toggle so stale values are never trusted
         cpl_out <= {1'b0, ~cpl_out[4:0]};
         if (lkrd_in) begin
            busy <= 1'b1;
            cnt <= delay_in;
         end else if (busy && cnt == 3'h0) begin
            busy <= 1'b0;
            cpl_out <= {2'b11, data_in, port_in};
         end else if (busy) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking testbench of the switch lock controller.
`include "slc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   slc_pkg::slc_up_tlp_t up = '0;
   slc_pkg::slc_dn_cpl_t cpl;
   slc_pkg::slc_dn_head_t [`SLC_NPORTS-1:0] head = '0;
   logic [7:0] dn_emp = 8'hff;
   logic [7:0] up_emp = 8'hff;
   logic root_emp = 1'b1;
   logic cpl_data = 1'b1;
   logic [2:0] cpl_dly = 3'h0;
   logic lkrd, cpl_v, cpl_d, unl, dnl, flag, viol;
   logic [2:0] lkrd_p, unl_p, lport, dest, src;
   logic [7:0] sts, hold, obs;
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] rng = 32'h00011c8c;
   initial forever #5 clk = ~clk;
   slc_lock_ctrl i_slc_lock_ctrl (.core_clk_in(clk), .rst_in(rst), .up_tlp_in(up),
      .dn_cpl_in(cpl), .dn_head_in(head), .posted_dn_empty_in(dn_emp),
      .posted_up_empty_in(up_emp), .posted_root_empty_in(root_emp), .fwd_lkrd_out(lkrd),
      .fwd_lkrd_port_out(lkrd_p), .fwd_cpl_out(cpl_v), .fwd_cpl_data_out(cpl_d),
      .fwd_unlock_out(unl), .fwd_unlock_port_out(unl_p), .dn_locked_out(dnl),
      .locked_port_out(lport), .switch_locked_flag_out(flag),
      .switch_status_register_out(sts), .hold_out(hold), .viol_out(viol));
   slc_cpl_model i_slc_cpl_model (.core_clk_in(clk), .rst_in(rst), .lkrd_in(lkrd),
      .port_in(lkrd_p), .data_in(cpl_data), .delay_in(cpl_dly), .cpl_out(cpl));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task send(input logic [2:0] k, input logic [2:0] d);
      @(posedge clk);
      up <= {1'b1, k, d};
      @(posedge clk);
      up <= '0;
   endtask
   task drain_q;
      for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(posedge clk);
      chk("pending", 8'(exp_q.size()), 8'h00);
   endtask
   // Registered hold shows one edge after the head is presented; checked after two
   task hchk(input logic [2:0] s, input logic [2:0] d, input logic e);
      @(posedge clk);
      head[s] <= {1'b1, d};
      repeat (2) @(posedge clk);
      #1 chk("hold", {7'h0, hold[s]}, {7'h0, e});
   endtask
   always @(negedge clk) begin
      if (lkrd || cpl_v || unl) begin
         obs = {lkrd, cpl_v, unl, cpl_v & cpl_d, 1'b0, lkrd ? lkrd_p : (unl ? unl_p : 3'h0)};
         chk("event", obs, exp_q.size() != 0 ? exp_q.pop_front() : 8'hff);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict;
      end
   end
   initial begin
      @(posedge clk);
      #1 chk("reset", {dnl, flag, lport, viol, |hold, |sts}, 8'h00);
      @(posedge clk);
      rst <= 1'b0;
      for (int t = 0; t < 6; t++) begin
         rng = xs(rng);
         dest = 3'(rng % 7) + 3'h1;
         src = (dest % 3'h7) + 3'h1;
         cpl_data <= ~t[0];
         cpl_dly <= rng[10:8];
         dn_emp <= ~(8'h01 << dest);
         up_emp <= ~(8'h01 << dest);
         send(`SLC_KIND_LKRD, dest);
         exp_q.push_back({5'h10, dest});
         exp_q.push_back({3'b010, ~t[0], 4'h0});
         repeat (rng[2:0]) @(posedge clk);
         dn_emp <= 8'hff;
         repeat (rng[5:3]) @(posedge clk);
         up_emp <= 8'hff;
         drain_q;
         chk("status", sts, {7'h0, ~t[0]});
         chk("locked", {4'h0, dnl, lport}, {4'h0, 1'b1, dest});
         hchk(src, dest, 1'b1);
         hchk(src, 3'h0, ~t[0]);
         hchk(src, (src % 3'h7) + 3'h1, 1'b0);
         if (!t[0]) begin
            cpl_data <= 1'b0;
            send(`SLC_KIND_LKRD, dest);
            exp_q.push_back({5'h10, dest});
            exp_q.push_back(8'h40);
            drain_q;
            chk("relock", {7'h0, flag}, 8'h01);
            send(`SLC_KIND_MWR, dest);
            @(negedge clk) chk("viol", {7'h0, viol}, 8'h00);
            send(`SLC_KIND_CFG, `SLC_UP_PORT);
            @(negedge clk) chk("viol", {7'h0, viol}, 8'h01);
         end
         root_emp <= 1'b0;
         send(`SLC_KIND_UNLOCK, dest);
         exp_q.push_back({5'h04, dest});
         repeat (rng[13:11]) @(posedge clk);
         root_emp <= 1'b1;
         drain_q;
         chk("unlocked", {6'h0, dnl, flag}, 8'h00);
         hchk(src, dest, 1'b0);
         head[src] <= '0;
         $display("test %0d done", t);
      end
      print_verdict;
   end
endmodule
`default_nettype wire
